// [acs_cfg.svh]
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// output word layout
`define ACS_EOC_BIT 31
`define ACS_FILLER_BIT 30
`define ACS_SIGN_BIT 29
`define ACS_MSB_BIT 28
`define ACS_LSB_BIT 5

// serial frame counts
`define ACS_LAST_FALL 6'd31
`define ACS_ABORT_FALL 6'd4
`define ACS_CODE_BITS 3'd5

// conversion length: mult * ratio + offset conversion clocks
`define ACS_CONV_MULT 32'd40
`define ACS_CONV_OFFSET 32'd170

// log2 of the ratio for rate codes 1 and f and the default
`define ACS_SHIFT_64 5'd6
`define ACS_SHIFT_256 5'd8
`define ACS_SHIFT_32768 5'd15

`endif

// [acs_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module acs_host_model (
  // clock and serial pins
  input wire logic mclk,
  input wire logic sdo,
  output logic sck,
  output logic cs_n,
  output logic sdi
);
  // idle: deselected, serial clock parked low
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // select, then n serial clocks; code goes out msb first on the first rises
  task automatic frame(input logic [4:0] code, input int n, output logic [31:0] got);
    got = '0;
    @(negedge mclk) cs_n = 1'b0;
    repeat (5) @(negedge mclk);
    #37;
    for (int i = 0; i < n; i++) begin
      sdi = (i < 5) ? code[4 - i] : i[0];
      #80 sck = 1'b1;
      got = {got[30:0], sdo};
      #80 sck = 1'b0;
    end
    #20;
  endtask : frame

  // deselect; after the fifth fall this cuts the frame short
  task automatic release_cs();
    @(negedge mclk) cs_n = 1'b1;
  endtask : release_cs
endmodule : acs_host_model
`default_nettype wire

// [acs_pkg.sv]
`default_nettype none
package acs_pkg;

  // converter cycle, gray along convert -> sleep -> output
  typedef enum logic [1:0] {
    ACS_CONVERT = 2'b00,
    ACS_SLEEP = 2'b01,
    ACS_OUTPUT = 2'b11
  } acs_state_t;

  typedef logic [4:0] acs_code_t;

endpackage : acs_pkg
`default_nettype wire

// [acs_result_port.sv]
// Overview of operation
// [R1] each result leaves as one 32-bit serial word
// [R2] three status bits lead the word ahead of the number
// [R3] bits 28..5 carry the 24-bit result, MSB first
// [R4] bits 4..0 carry five sub-LSB bits
// [R5] bit 31 is conversion_done_n, high converting, low when done
// [R6] bit 30, the filler_bit, is always low
// [R7] bit 29, the sign_bit, is high for positive input
// [R8] bits 29 and 28 both high on overrange, both low on underrange
// [R9] beyond twice full_scale either range code may appear
// [R10] serial output is released while chip select is high
// [R11] with chip select low the output shows conversion_done_n live
// [R12] chip select rising after the fifth fall aborts and converts
// [R13] serial input low picks 880Hz, high picks 6.9Hz
// [R14] level changes in convert or sleep apply after next readout
// [R15] a serial rate code during readout sets the next conversion
// [R16] host should hold the serial input steady during readout; the host model toggles it after the five code bits
// [R17] code bits are taken on the first five rising edges only
// [R18] busy is high while converting and drops when done
// [R19] busy stays low in readout and rises when it ends
// [R20] output bits change on serial clock falling edges
// [R21] readout ends after 32 bits or chip select high
// [R22] code sampled MSB first; maps codes to oversampling_ratio
// [R23] conversion takes 40 times the ratio plus 170 clocks
// [R24] the word is captured once at completion and held
// [R25] after reset the rate code follows the serial input level
`timescale 1ns/100ps
`default_nettype none
`include "acs_cfg.svh"

module acs_result_port
  import acs_pkg::*;
#(
  parameter logic [31:0] CONV_MULT = `ACS_CONV_MULT,
  parameter logic [31:0] CONV_OFFSET = `ACS_CONV_OFFSET
) (
  // system clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // serial link
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SDI,
  output logic SDO_OUT,
  output logic SDO_OE,
  // status
  output logic BUSY,
  output logic CONV_START,
  output logic [4:0] RATE_CODE,
  // analog core result
  input wire logic SAMPLE_SIGN,
  input wire logic [23:0] SAMPLE_RESULT,
  input wire logic [4:0] SAMPLE_SUB,
  input wire logic SAMPLE_OVER,
  input wire logic SAMPLE_UNDER
);

  // system domain state
  acs_state_t state;
  acs_state_t next_state;
  logic [31:0] conv_cnt;
  logic [31:0] next_conv_cnt;
  logic [31:0] word;
  logic [31:0] next_word;
  acs_code_t rate_code;
  acs_code_t next_rate_code;
  logic busy;
  logic next_busy;
  logic link_clear;
  logic next_link_clear;
  logic conv_start;
  logic next_conv_start;
  logic [31:0] conv_len;
  logic [4:0] shift;
  logic sgn;
  logic msb;

  // synchronisers into the system domain
  logic cs_s1;
  logic cs_s2;
  logic sdi_s1;
  logic sdi_s2;
  logic p5_s1;
  logic p5_s2;
  logic dn_s1;
  logic dn_s2;

  // link domain state
  logic [5:0] fall_cnt;
  logic [5:0] next_fall_cnt;
  logic sdo_bit;
  logic next_sdo_bit;
  logic past5;
  logic next_past5;
  logic done32;
  logic next_done32;
  logic [2:0] rise_cnt;
  logic [2:0] next_rise_cnt;
  acs_code_t code_sr;
  acs_code_t next_code_sr;
  logic [5:0] bit_idx;

  // rate code to log2 of oversampling_ratio, top bit ignored
  function automatic logic [4:0] osr_shift(input acs_code_t code);
    logic [4:0] s;
    s = `ACS_SHIFT_256;
    case (code[3:0])
      4'h1: s = `ACS_SHIFT_64;
      4'h2: s = 5'd7;
      4'h4: s = 5'd9;
      4'h5: s = 5'd10;
      4'h6: s = 5'd11;
      4'h7: s = 5'd12;
      4'h8: s = 5'd13;
      4'h9: s = 5'd14;
      4'hf: s = `ACS_SHIFT_32768;
      default: s = `ACS_SHIFT_256; // 0000 and 0011 both land here
    endcase
    return s;
  endfunction : osr_shift

  // two-flop synchronisers, first stage feeds only the second
  always_ff @(posedge MCLK) begin
    cs_s1 <= CS_N;
    cs_s2 <= cs_s1;
    sdi_s1 <= SDI;
    sdi_s2 <= sdi_s1;
    p5_s1 <= past5;
    p5_s2 <= p5_s1;
    dn_s1 <= done32;
    dn_s2 <= dn_s1;
  end

  // conversion length and range-flagged status bits
  always_comb begin
    shift = osr_shift(rate_code); // [R22]
    conv_len = (CONV_MULT << shift) + CONV_OFFSET; // [R23]
    // over wins when the core raises both flags past twice full_scale [R9]
    sgn = SAMPLE_OVER ? 1'b1 : (SAMPLE_UNDER ? 1'b0 : SAMPLE_SIGN); // [R8] [R7] [R9]
    msb = SAMPLE_OVER ? 1'b1 : (SAMPLE_UNDER ? 1'b0 : SAMPLE_RESULT[23]); // [R8]
  end

  // converter cycle next values
  always_comb begin
    next_state = state;
    next_conv_cnt = conv_cnt;
    next_word = word;
    next_rate_code = rate_code;
    next_busy = busy;
    next_conv_start = 1'b0;
    case (state)
      ACS_CONVERT: begin
        next_busy = 1'b1; // [R18]
        if (conv_cnt >= conv_len - 32'd1) begin
          // one-step capture, status ahead of the number [R24] [R2]
          next_word = {1'b0, 1'b0, sgn, msb, SAMPLE_RESULT[22:0], SAMPLE_SUB}; // [R5] [R6] [R3] [R4]
          next_state = ACS_SLEEP;
          next_busy = 1'b0; // [R18]
          next_conv_cnt = 32'd0;
        end else begin
          next_conv_cnt = conv_cnt + 32'd1;
        end
      end
      ACS_SLEEP: begin
        if (!cs_s2) begin
          next_state = ACS_OUTPUT;
        end
      end
      ACS_OUTPUT: begin
        // busy stays low here [R19]
        if (dn_s2 || (cs_s2 && p5_s2)) begin
          // end of word or abort starts a new conversion [R21] [R12]
          next_state = ACS_CONVERT;
          next_busy = 1'b1; // [R19]
          next_conv_start = 1'b1;
          next_conv_cnt = 32'd0;
          next_rate_code = code_sr; // [R15] [R14] [R13]
        end else if (cs_s2) begin
          next_state = ACS_SLEEP;
        end
      end
      default: begin
        next_state = ACS_CONVERT;
      end
    endcase
    next_link_clear = (next_state != ACS_OUTPUT);
  end

  // converter cycle registers
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state <= ACS_CONVERT;
      conv_cnt <= 32'd0;
      word <= 32'h00000000;
      rate_code <= {5{sdi_s2}}; // [R25]
      busy <= 1'b1;
      link_clear <= 1'b1;
      conv_start <= 1'b0;
    end else begin
      state <= next_state;
      conv_cnt <= next_conv_cnt;
      word <= next_word;
      rate_code <= next_rate_code;
      busy <= next_busy;
      link_clear <= next_link_clear;
      conv_start <= next_conv_start;
    end
  end

  // falling-edge side: bit counter and output bit
  always_comb begin
    bit_idx = 6'd30 - fall_cnt;
    next_fall_cnt = (fall_cnt > `ACS_LAST_FALL) ? fall_cnt : fall_cnt + 6'd1;
    if (fall_cnt >= `ACS_LAST_FALL) begin
      next_sdo_bit = 1'b1; // new conversion shows as high
    end else begin
      next_sdo_bit = word[bit_idx[4:0]]; // [R1] [R20]
    end
    next_past5 = past5 | (fall_cnt == `ACS_ABORT_FALL); // [R12]
    next_done32 = done32 | (fall_cnt == `ACS_LAST_FALL); // [R21]
  end

  // word is static while the link runs, so it is read unsynchronised
  always_ff @(negedge SCK or posedge link_clear) begin
    if (link_clear) begin
      fall_cnt <= 6'd0;
      sdo_bit <= 1'b0;
      past5 <= 1'b0;
      done32 <= 1'b0;
    end else begin
      fall_cnt <= next_fall_cnt;
      sdo_bit <= next_sdo_bit;
      past5 <= next_past5;
      done32 <= next_done32;
    end
  end

  // rising-edge side: rate code shifter, first five edges only
  always_comb begin
    next_rise_cnt = rise_cnt;
    next_code_sr = code_sr;
    if (rise_cnt < `ACS_CODE_BITS) begin
      next_code_sr = {code_sr[3:0], SDI}; // [R22] [R17]
      next_rise_cnt = rise_cnt + 3'd1;
    end
  end

  always_ff @(posedge SCK or posedge link_clear) begin
    if (link_clear) begin
      rise_cnt <= 3'd0;
      code_sr <= 5'h00;
    end else begin
      rise_cnt <= next_rise_cnt;
      code_sr <= next_code_sr;
    end
  end

  // pins: live status outside readout, shifted bit inside
  always_comb begin
    SDO_OE = !CS_N; // [R10]
    SDO_OUT = link_clear ? busy : sdo_bit; // [R11] [R5]
    BUSY = busy;
    CONV_START = conv_start;
    RATE_CODE = rate_code;
  end

  // checks, all in the system domain
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_capture;
    state == ACS_CONVERT && next_state == ACS_SLEEP;
  endsequence

  sequence s_frame_end;
    state == ACS_OUTPUT && dn_s2;
  endsequence

  chk_filler_low: assert property ( // [R6]
    s_capture |=> word[`ACS_FILLER_BIT] == 1'b0 && word[`ACS_EOC_BIT] == 1'b0)
    else $error("filler or done flag not low in captured word");

  chk_over_code: assert property ( // [R8]
    (s_capture and SAMPLE_OVER) |=> word[`ACS_SIGN_BIT:`ACS_MSB_BIT] == 2'b11)
    else $error("overrange code missing");

  chk_sign_field: assert property ( // [R7]
    (s_capture and !SAMPLE_OVER && !SAMPLE_UNDER) |=> word[`ACS_SIGN_BIT] == $past(SAMPLE_SIGN))
    else $error("sign bit wrong");

  chk_result_field: assert property ( // [R3]
    (s_capture and !SAMPLE_OVER && !SAMPLE_UNDER)
      |=> word[`ACS_MSB_BIT:`ACS_LSB_BIT] == $past(SAMPLE_RESULT))
    else $error("result field wrong");

  chk_word_hold: assert property ( // [R24]
    (state != ACS_CONVERT && $past(state) != ACS_CONVERT) |-> $stable(word))
    else $error("word changed outside conversion");

  chk_sleep_busy: assert property ( // [R18]
    s_capture |=> !BUSY [*2])
    else $error("busy not low after completion");

  chk_busy_end: assert property ( // [R19]
    s_frame_end |=> BUSY && CONV_START && state == ACS_CONVERT)
    else $error("busy did not rise at end of readout");

  chk_rate_apply: assert property ( // [R15]
    s_frame_end |=> RATE_CODE == $past(code_sr))
    else $error("rate code not taken at end of readout");

  chk_abort_start: assert property ( // [R12]
    (state == ACS_OUTPUT && cs_s2 && p5_s2) |=> state == ACS_CONVERT ##1 BUSY)
    else $error("abort did not start a conversion");

  chk_sdo_hiz: assert property ( // [R10]
    CS_N |-> !SDO_OE)
    else $error("serial output driven with chip select high");

  chk_eoc_live: assert property ( // [R11]
    (state == ACS_CONVERT && $past(state) == ACS_CONVERT) |-> SDO_OUT)
    else $error("done flag not shown during conversion");

endmodule : acs_result_port
`default_nettype wire

// [adc_serial_result_port_test.sv]
`timescale 1ns/100ps
`default_nettype none
module adc_serial_result_port_test;
  import acs_pkg::*;
  localparam int MULT = 1;
  localparam int OFFS = 10;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic SAMPLE_SIGN = 1'b1;
  logic SAMPLE_OVER = 1'b0;
  logic SAMPLE_UNDER = 1'b0;
  logic [23:0] SAMPLE_RESULT = 24'h9a5c3e;
  logic [4:0] SAMPLE_SUB = 5'h15;
  logic SCK, CS_N, SDI, SDO_OUT, SDO_OE, BUSY, CONV_START;
  logic [4:0] RATE_CODE;
  logic [31:0] exp_w, got_w;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  // the pin as the host sees it
  wire logic sdo_pin = SDO_OE ? SDO_OUT : 1'bz;

  always #50 MCLK = ~MCLK;

  acs_result_port #(.CONV_MULT(MULT), .CONV_OFFSET(OFFS)) dut (.MCLK(MCLK), .RST_N(RST_N), .SCK(SCK),
    .CS_N(CS_N), .SDI(SDI), .SDO_OUT(SDO_OUT), .SDO_OE(SDO_OE), .BUSY(BUSY), .CONV_START(CONV_START),
    .RATE_CODE(RATE_CODE), .SAMPLE_SIGN(SAMPLE_SIGN), .SAMPLE_RESULT(SAMPLE_RESULT),
    .SAMPLE_SUB(SAMPLE_SUB), .SAMPLE_OVER(SAMPLE_OVER), .SAMPLE_UNDER(SAMPLE_UNDER));
  acs_host_model host (.mclk(MCLK), .sdo(sdo_pin), .sck(SCK), .cs_n(CS_N), .sdi(SDI));

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // expected output word from the core's flags
  function automatic logic [31:0] word(input logic s, input logic [23:0] r, input logic [4:0] b,
                                       input logic ov, input logic un);
    logic [1:0] top;
    top = ov ? 2'b11 : (un ? 2'b00 : {s, r[23]});
    return {2'b00, top, r[22:0], b};
  endfunction : word

  // busy-high cycles expected for a rate code
  function automatic int conv_len(input logic [4:0] c);
    int ratio;
    ratio = (c[3:0] == 4'hf) ? 32768 : ((c[3:0] inside {4'h1, 4'h2, [4'h4:4'h9]}) ? (32 << c[3:0]) : 256);
    return MULT * ratio + OFFS; // busy rises and falls on edges exactly this many cycles apart
  endfunction : conv_len

  // read n bits with a code, then follow the conversion that this starts
  task automatic t_read(input logic [4:0] code, input int n);
    int k;
    host.frame(code, n, got_w);
    chk("word", exp_w >> (32 - n), got_w);
    if (n < 32)
      host.release_cs();
    else
      chk("sdo after word", 32'h1, {31'h0, sdo_pin});
    k = 0;
    do begin
      @(negedge MCLK);
      k++;
    end while (BUSY !== 1'b1 && k < 10);
    chk("busy rise", 32'h1, {31'h0, BUSY});
    chk("start pulse", 32'h1, {31'h0, CONV_START});
    chk("rate code", {27'h0, code}, {27'h0, RATE_CODE});
    k = 0;
    while (BUSY === 1'b1 && k < 40000) begin
      k++;
      @(negedge MCLK);
    end
    chk("conv length", conv_len(code), k);
    if (n == 32) begin
      chk("done flag live", 32'h0, {31'h0, sdo_pin});
      host.release_cs();
      #1 chk("sdo released", 32'h0, {31'h0, SDO_OE});
    end
    $display("read code %h length %0d done", code, n);
  endtask : t_read

  // cut a hang short
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    repeat (5) @(negedge MCLK);
    chk("busy in reset", 32'h1, {31'h0, BUSY});
    chk("code in reset", 32'h0, {27'h0, RATE_CODE});
    chk("oe deselected", 32'h0, {31'h0, SDO_OE});
    RST_N = 1'b1;
    // select during the first conversion and watch the flag fall
    host.frame(5'h00, 0, got_w);
    chk("flag converting", 32'h1, {31'h0, sdo_pin});
    while (BUSY !== 1'b0 && cycles < 2000) @(negedge MCLK);
    chk("flag done", 32'h0, {31'h0, sdo_pin});
    host.release_cs();
    $display("status test done");
    exp_w = word(1'b1, 24'h9a5c3e, 5'h15, 1'b0, 1'b0);
    @(negedge MCLK) SAMPLE_OVER = 1'b1;
    t_read(5'h01, 32);
    exp_w = word(1'b1, 24'h9a5c3e, 5'h15, 1'b1, 1'b0);
    @(negedge MCLK) SAMPLE_OVER = 1'b0;
    SAMPLE_UNDER = 1'b1;
    t_read(5'h03, 32);
    exp_w = word(1'b1, 24'h9a5c3e, 5'h15, 1'b0, 1'b1);
    @(negedge MCLK) SAMPLE_UNDER = 1'b0;
    SAMPLE_SIGN = 1'b0;
    SAMPLE_RESULT = 24'h3c0f01;
    t_read(5'h12, 5);
    exp_w = word(1'b0, 24'h3c0f01, 5'h15, 1'b0, 1'b0);
    t_read(5'h1f, 32);
    finish_test();
  end
endmodule : adc_serial_result_port_test
`default_nettype wire
